//--- chan_defs.vh
// Constants for the timer channel control and status block
`ifndef CHAN_DEFS_VH
`define CHAN_DEFS_VH

// Register byte addresses
`define ADDR_CCS 12'h000
`define ADDR_VALUE 12'h004
`define ADDR_GLOBAL 12'h008
`define ADDR_W 12

// channel_control_status fields
`define CCS_FLAG 7
`define CCS_IRQ_EN 6
`define CCS_MSH 5
`define CCS_MSL 4
`define CCS_ELS_HI 3
`define CCS_ELS_LO 2
`define CCS_RESET 8'h00

// Global control field
`define GLB_CPWM 0

// Edge/level select codes
`define ELS_OFF 2'h0
`define ELS_RISE 2'h1
`define ELS_FALL 2'h2
`define ELS_BOTH 2'h3

// Mode select codes with center-align off
`define MS_CAPTURE 2'h0
`define MS_COMPARE 2'h1

`define VALUE_RESET 16'h0000
`define DATA_ZERO 32'h0000_0000

`endif

//--- pin_sync.v
// Three-stage pin synchroniser with qualified edge pulses
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
	input wire i_clk,
	input wire i_reset,
	input wire i_pin,
	output reg o_rise,
	output reg o_fall
);
	reg s1_r;
	reg s2_r;
	reg s3_r;
	reg level_r;
	// A change counts only once stages two and three agree
	wire agree = (s2_r == s3_r);

	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			level_r <= 1'b0;
			o_rise <= 1'b0;
			o_fall <= 1'b0;
		end else begin
			s1_r <= i_pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			o_rise <= agree && s3_r && !level_r;
			o_fall <= agree && !s3_r && level_r;
			if (agree) begin
				level_r <= s3_r;
			end
		end
	end
endmodule // pin_sync
`default_nettype wire

//--- event_flag.v
// Sticky event flag with read-then-write-zero clear
`timescale 1ns/1ps
`default_nettype none
module event_flag (
	input wire i_clk,
	input wire i_reset,
	input wire i_event,
	input wire i_read_done,
	input wire i_write_done,
	input wire i_write_bit,
	output reg o_flag
);
	reg armed_r;

	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_flag <= 1'b0;
			armed_r <= 1'b0;
		end else begin
			if (i_event) begin
				o_flag <= 1'b1;
				armed_r <= 1'b0;
			end else if (i_write_done) begin
				if (armed_r && !i_write_bit) begin
					o_flag <= 1'b0;
				end
				armed_r <= 1'b0;
			end else if (i_read_done && o_flag) begin
				armed_r <= 1'b1;
			end
		end
	end
endmodule // event_flag
`default_nettype wire

//--- timer_channel.v
// One timer channel: mode control, event flag, pin logic, APB registers
`include "chan_defs.vh"
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Capture edge sets the event flag
// - Compare or edge PWM match sets flag
// - Center PWM: every match sets flag
// - Request while flag and enable set
// - Read with flag, then write zero clears
// - New event restarts the clear sequence
// - Writing one is ignored; reset clears
// - Bit six is the interrupt enable
// - Mode high set means edge PWM
// - Mode low picks capture or compare
// - Edge/level zero releases the pin
// - Capture edge: rise, fall or both
// - Compare pin: none, toggle, low, high
// - Edge PWM polarity from edge/level
// - Center-align forces center PWM
// - Center-align bit drives up/down counting
module timer_channel #(
	parameter VALUE_W = 16
) (
	input wire i_clk,
	input wire i_reset,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [31:0] i_paddr,
	input wire [31:0] i_pwdata,
	output reg [31:0] o_prdata,
	output reg o_pready,
	output reg o_pslverr,
	input wire [VALUE_W-1:0] i_counter,
	input wire i_count_tick,
	input wire i_count_down,
	input wire i_period_start,
	input wire i_pin,
	output reg o_pin_out,
	output reg o_pin_oe,
	output reg o_irq,
	output reg o_capture,
	output reg o_center_align
);
	reg irq_en_r;
	reg ms_high_r;
	reg ms_low_r;
	reg [1:0] els_r;
	reg [VALUE_W-1:0] value_r;
	reg pin_level_r;
	reg pin_level_nxt;
	reg pin_oe_nxt;
	wire flag;
	wire rise;
	wire fall;
	reg mode_cpwm;
	reg mode_epwm;
	reg mode_cap;
	reg mode_cmp;

	// Bus word and control byte widths
	localparam DATA_W = 32;
	localparam CCS_W = 8;

	// Register decode shared by the three slots
	function addr_is;
		input [`ADDR_W-1:0] a;
		input [`ADDR_W-1:0] slot;
		begin
			addr_is = (a == slot);
		end
	endfunction

	// Read word of a slot; unused upper bits read zero
	function [DATA_W-1:0] read_word;
		input sel_ccs;
		input sel_value;
		input sel_global;
		input [CCS_W-1:0] ccs;
		input [VALUE_W-1:0] value;
		input center;
		begin
			read_word = {DATA_W{1'b0}};
			if (sel_ccs) begin
				read_word[CCS_W-1:0] = ccs;
			end else if (sel_value) begin
				read_word[VALUE_W-1:0] = value;
			end else if (sel_global) begin
				read_word[`GLB_CPWM] = center;
			end
		end
	endfunction

	// APB: one wait state, answer registered
	// Registering pready costs a cycle but keeps
	// the decode off the bus return path.
	wire access = i_psel && i_penable;
	wire done = access && o_pready;
	// Upper address bits are ignored, so the slots alias
	wire [`ADDR_W-1:0] addr = i_paddr[`ADDR_W-1:0];
	wire hit_ccs = addr_is(addr, `ADDR_CCS);
	wire hit_value = addr_is(addr, `ADDR_VALUE);
	wire hit_global = addr_is(addr, `ADDR_GLOBAL);
	wire mapped = hit_ccs || hit_value || hit_global;
	wire wr_ccs = done && i_pwrite && hit_ccs;
	wire wr_value = done && i_pwrite && hit_value;
	wire wr_global = done && i_pwrite && hit_global;
	wire rd_ccs = done && !i_pwrite && hit_ccs;

	wire [7:0] ccs_read = {flag, irq_en_r, ms_high_r, ms_low_r, els_r,
		2'h0};

	// Exactly one mode flag is high at any time
	always @* begin
		mode_cpwm = 1'b0;
		mode_epwm = 1'b0;
		mode_cap = 1'b0;
		mode_cmp = 1'b0;
		if (o_center_align) begin
			mode_cpwm = 1'b1;
		// Mode high wins over mode low
		end else if (ms_high_r) begin
			mode_epwm = 1'b1;
		end else begin
			case ({ms_high_r, ms_low_r})
			`MS_CAPTURE: begin
				mode_cap = 1'b1;
			end
			`MS_COMPARE: begin
				mode_cmp = 1'b1;
			end
			default: begin
				mode_cap = 1'b0;
			end
			endcase
		end
	end
	// Pin released when select is zero
	wire pin_off = (els_r == `ELS_OFF);
	// Low-true PWM when low select bit set
	wire low_true = els_r[0];

	wire match = i_count_tick && (i_counter == value_r);
	wire cap_edge = mode_cap && !pin_off &&
		((rise && els_r[0]) || (fall && els_r[1]));
	wire chan_event = cap_edge || ((mode_cmp || mode_epwm || mode_cpwm)
		&& match);

	pin_sync u_sync (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_pin(i_pin),
		.o_rise(rise),
		.o_fall(fall)
	);

	event_flag u_flag (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_event(chan_event),
		.i_read_done(rd_ccs),
		.i_write_done(wr_ccs),
		.i_write_bit(i_pwdata[`CCS_FLAG]),
		.o_flag(flag)
	);

	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= `DATA_ZERO;
		end else begin
			o_pready <= access && !o_pready;
			if (access && !o_pready) begin
				o_pslverr <= !mapped;
				// Writes and holes return zero, never stale data
				if (i_pwrite || !mapped) begin
					o_prdata <= `DATA_ZERO;
				end else begin
					o_prdata <= read_word(hit_ccs, hit_value,
						hit_global, ccs_read, value_r,
						o_center_align);
				end
			end else begin
				o_pslverr <= 1'b0;
			end
		end
	end

	// Control bits; the flag lives in event_flag
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			irq_en_r <= 1'b0;
			ms_high_r <= 1'b0;
			ms_low_r <= 1'b0;
			els_r <= `ELS_OFF;
			o_center_align <= 1'b0;
		end else begin
			if (wr_ccs) begin
				irq_en_r <= i_pwdata[`CCS_IRQ_EN];
				ms_high_r <= i_pwdata[`CCS_MSH];
				ms_low_r <= i_pwdata[`CCS_MSL];
				els_r <= i_pwdata[`CCS_ELS_HI:`CCS_ELS_LO];
			end
			if (wr_global) begin
				o_center_align <= i_pwdata[`GLB_CPWM];
			end
		end
	end

	// Capture takes priority over a software write in the same cycle
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			value_r <= `VALUE_RESET;
			o_capture <= 1'b0;
		end else begin
			o_capture <= cap_edge;
			if (cap_edge) begin
				value_r <= i_counter;
			end else if (wr_value) begin
				value_r <= i_pwdata[VALUE_W-1:0];
			end
		end
	end

	// Pin action per mode
	// A match on the period-start tick wins in edge PWM,
	// which gives a clean zero duty cycle.
	// Level is held, not reset, when the pin is released,
	// so re-enabling resumes from the last driven value.
	always @* begin
		pin_level_nxt = pin_level_r;
		pin_oe_nxt = !pin_off && !mode_cap;
		if (pin_off || mode_cap) begin
			pin_level_nxt = pin_level_r;
		end else if (mode_cmp) begin
			if (match) begin
				case (els_r)
				`ELS_RISE: begin
					pin_level_nxt = !pin_level_r;
				end
				`ELS_FALL: begin
					pin_level_nxt = 1'b0;
				end
				`ELS_BOTH: begin
					pin_level_nxt = 1'b1;
				end
				default: begin
					pin_level_nxt = pin_level_r;
				end
				endcase
			end
		end else if (mode_epwm) begin
			if (match) begin
				pin_level_nxt = low_true;
			end else if (i_period_start) begin
				pin_level_nxt = !low_true;
			end
		end else if (match) begin
			// Up match ends, down match starts
			pin_level_nxt = i_count_down ? !low_true : low_true;
		end
	end

	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			pin_level_r <= 1'b0;
			o_pin_out <= 1'b0;
			o_pin_oe <= 1'b0;
			o_irq <= 1'b0;
		end else begin
			pin_level_r <= pin_level_nxt;
			o_pin_out <= pin_level_nxt;
			o_pin_oe <= pin_oe_nxt;
			o_irq <= flag && irq_en_r;
		end
	end
endmodule // timer_channel
`default_nettype wire

//--- pin_src.sv
// Model of the signal source on the channel pin
`timescale 1ns/1ps
`default_nettype none
module pin_src (
	input wire logic i_clk,
	input wire logic i_level,
	output logic o_pin
);
	initial o_pin = 1'h0;
	always @(posedge i_clk)
		o_pin <= i_level;
endmodule // pin_src
`default_nettype wire

//--- timer_channel_monitor.sv
// Checker of pin, flag and interrupt timing of the channel
`timescale 1ns/1ps
`default_nettype none
module channel_monitor #(
	parameter VALUE_W = 16
) (
	input wire i_clk,
	input wire i_reset,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [31:0] i_paddr,
	input wire [31:0] i_pwdata,
	input wire o_pready,
	input wire [VALUE_W-1:0] i_counter,
	input wire i_count_tick,
	input wire i_count_down,
	input wire i_period_start,
	input wire o_pin_out,
	input wire o_pin_oe,
	input wire o_irq,
	input wire o_capture
);
	logic [7:0] ccs_r;
	logic [VALUE_W-1:0] val_r;
	logic cpw_r;
	wire wr = i_psel && i_penable && o_pready && i_pwrite;
	wire mt = i_count_tick && i_counter == val_r;
	wire off = ccs_r[3:2] == 2'h0;
	wire cmp = !cpw_r && ccs_r[5:4] == 2'h1;
	wire epw = !cpw_r && ccs_r[5];
	wire rel = off || (!cpw_r && ccs_r[5:4] == 2'h0);
	// Shadow of the bus writes; captures never reach val_r
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			ccs_r <= 8'h00;
			val_r <= '0;
			cpw_r <= 1'h0;
		end else if (wr && i_paddr[11:0] == 12'h000) begin
			ccs_r <= i_pwdata[7:0];
		end else if (wr && i_paddr[11:0] == 12'h004) begin
			val_r <= i_pwdata[VALUE_W-1:0];
		end else if (wr && i_paddr[11:0] == 12'h008) begin
			cpw_r <= i_pwdata[0];
		end
	end
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);
	toggle_pin_a: assert property (cmp && ccs_r[3:2] == 2'h1 && mt && !wr
		|=> o_pin_out != $past(o_pin_out)) else $error("no toggle");
	drive_pin_a: assert property (cmp && ccs_r[3] && mt && !wr
		|=> o_pin_out == $past(ccs_r[2])) else $error("bad compare level");
	pwm_match_a: assert property (epw && !off && mt && !wr
		|=> o_pin_out == $past(ccs_r[2])) else $error("bad pwm match");
	pwm_start_a: assert property (epw && !off && !mt && !wr
		&& i_period_start |=> o_pin_out != $past(ccs_r[2]))
		else $error("bad pwm start");
	center_up_a: assert property (cpw_r && !off && mt && !wr
		&& !i_count_down |=> o_pin_out == $past(ccs_r[2]))
		else $error("bad center level");
	pin_free_a: assert property (rel && $past(rel) |-> !o_pin_oe)
		else $error("released pin driven");
	irq_mask_a: assert property (!ccs_r[6] && $past(!ccs_r[6])
		|-> !o_irq) else $error("masked irq raised");
	flag_irq_a: assert property (ccs_r[6] && !rel && mt && !wr
		|-> ##2 o_irq) else $error("match irq missing");
	cap_irq_a: assert property (o_capture && ccs_r[6]
		|-> ##[0:2] o_irq) else $error("capture irq missing");
endmodule // channel_monitor
bind timer_channel channel_monitor #(.VALUE_W(VALUE_W)) mon (.*);
`default_nettype wire

//--- tb_timer_channel.sv
// Self-checking testbench for the timer channel block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((e) !== (a)) begin \
	num_errors++; $display("BAD %s exp %h got %h", n, e, a); end end
module tb_timer_channel;
	logic i_clk = 1'h0, i_reset = 1'h1, i_psel = 1'h0, i_penable = 1'h0;
	logic i_pwrite = 1'h0, i_count_tick = 1'h0, i_count_down = 1'h0;
	logic i_period_start = 1'h0, lvl = 1'h0, o_pready, o_pslverr;
	logic o_pin_out, o_pin_oe, o_irq, o_capture, o_center_align, src;
	logic [31:0] i_paddr = 32'h0, i_pwdata = 32'h0, o_prdata;
	logic [31:0] seed = 32'h0000000f;
	logic [15:0] i_counter = 16'h0, v;
	logic [32:0] q[$], e;
	int num_errors = 0, comparisons = 0, caps = 0;
	wire i_pin = o_pin_oe ? o_pin_out : src;
	timer_channel dut (.*);
	pin_src far (.i_clk, .i_level(lvl), .o_pin(src));
	always #5 i_clk = ~i_clk;
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	task automatic xfer(input logic w, input logic [3:0] a,
			input logic [31:0] d, input logic [32:0] x);
		q.push_back(x);
		i_psel <= 1'h1;
		i_pwrite <= w;
		i_paddr <= {28'h0, a};
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'h1;
		@(posedge i_clk);
		while (o_pready !== 1'h1)
			@(posedge i_clk);
		i_psel <= 1'h0;
		i_penable <= 1'h0;
		@(posedge i_clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		xfer(1'h1, a, d, 33'h0);
	endtask
	task automatic rd(input logic [3:0] a, input logic [32:0] x);
		xfer(1'h0, a, 32'h0, x);
	endtask
	// Bit 1 of m counts down, bit 0 marks a period start
	task automatic hit(input logic [15:0] c, input logic [1:0] m);
		i_counter <= c;
		i_count_tick <= 1'h1;
		{i_count_down, i_period_start} <= m;
		@(posedge i_clk);
		i_count_tick <= 1'h0;
		i_period_start <= 1'h0;
		repeat (3) @(posedge i_clk);
	endtask
	task finish_test();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge i_clk)
		if (i_psel && i_penable && o_pready === 1'h1) begin
			e = q.pop_front();
			`CHK("apb", e, {o_pslverr, o_prdata})
		end
	always @(posedge i_clk)
		if (o_capture === 1'h1)
			caps++;
	initial begin
		repeat (20000) @(posedge i_clk);
		num_errors++;
		finish_test();
	end
	initial begin
		v = rnd() | 16'h0001;
		repeat (10) @(posedge i_clk);
		i_reset <= 1'h0;
		@(posedge i_clk);
		rd(4'h0, 33'h0);
		rd(4'hc, {1'h1, 32'h0});
		wr(4'h0, 32'hff);
		rd(4'h0, 33'h7c);
		wr(4'h4, {16'h0, v});
		// compare pin actions, highest code first
		for (int s = 3; s >= 0; s--) begin
			wr(4'h0, 32'h50 | s << 2);
			hit(v, 2'h0);
			`CHK("oe", s != 0, o_pin_oe)
			if (s != 0) `CHK("pin", s != 2, o_pin_out)
			`CHK("irq", 1'h1, o_irq)
			rd(4'h0, 33'hd0 | s << 2);
		end
		wr(4'h0, 32'h50);
		rd(4'h0, 33'h50);
		hit(v, 2'h0);
		rd(4'h0, 33'hd0);
		hit(v, 2'h0);
		wr(4'h0, 32'h50);
		rd(4'h0, 33'hd0);
		// Mode low is random: edge PWM must ignore it
		for (int s = 1; s <= 2; s++) begin
			wr(4'h0, 32'h20 | s << 2 | rnd() & 32'h10);
			hit(16'h0, 2'h1);
			`CHK("start", s[1], o_pin_out)
			hit(v, 2'h0);
			`CHK("match", s[0], o_pin_out)
		end
		wr(4'h8, 32'h1);
		wr(4'h0, 32'h48);
		rd(4'h8, 33'h1);
		`CHK("ca", 1'h1, o_center_align)
		hit(v, 2'h2);
		`CHK("down", 1'h1, o_pin_out)
		hit(v, 2'h0);
		`CHK("up", 1'h0, o_pin_out)
		rd(4'h0, 33'hc8);
		// pin released before leaving center mode
		wr(4'h0, 32'h40);
		wr(4'h8, 32'h0);
		v = rnd();
		i_counter <= v;
		for (int s = 1; s <= 3; s++) begin
			wr(4'h0, 32'h40 | s << 2);
			lvl <= 1'h1;
			repeat (8) @(posedge i_clk);
			rd(4'h0, 33'h40 | s << 2 | s[0] << 7);
			wr(4'h0, 32'h40 | s << 2);
			lvl <= 1'h0;
			repeat (8) @(posedge i_clk);
			rd(4'h0, 33'h40 | s << 2 | s[1] << 7);
		end
		rd(4'h4, {17'h0, v});
		// select zero leaves the pin to others
		wr(4'h0, 32'h40);
		lvl <= 1'h1;
		repeat (8) @(posedge i_clk);
		`CHK("oe0", 1'h0, o_pin_oe)
		rd(4'h0, 33'h40);
		`CHK("caps", 4, caps)
		finish_test();
	end
endmodule // tb_timer_channel
`default_nettype wire
